// >>> rtl/csc_pkg.sv
// Constants and types for the clock source and sleep control block
// Summary of operation
// - Fuse codes 0001..0100 pick the internal RC oscillator at 1, 2, 4, 8 MHz.
// - During reset the factory calibration byte is copied into the trim register.
// - RC and external clock start in 6 cycles plus none, 4.1 ms or 65 ms.
// - Trim maps monotonically to frequency, zero lowest and all ones highest.
// - Trim range spans about 50-100, 75-150 and 100-200 percent of nominal.
// - Reset time-out is timed by the separate watchdog oscillator.
// - Fuse code 0000 takes the system clock from the external clock pin.
// - Halt sleeps only while sleep enable is one.
// - Mode field decodes idle, noise reduction, power-down, power-save, standby modes.
// - Standby and extended standby only with a crystal or resonator source.
// - Interrupt wake holds the core four cycles beyond start-up, then resumes.
// - Register file and data memory contents are kept across sleep.
// - Reset during sleep wakes and restarts at the reset vector.
// - Mode bits at 7, 5, 4, sleep enable at 6, all cleared by reset.
// - Idle gates only core and program memory clocks.
// - Idle wakes on external pin and internal peripheral interrupts.
// - Entering idle with the converter enabled starts a conversion.
// - Power-down stops all clocks and applies the six-cycle start-up count on wake.
// - Standby keeps the oscillator running and resumes after the six-cycle start-up and four-cycle wake hold.
package csc_pkg;

  localparam logic [11:0] ADDR_RC_TRIM   = 12'h000;
  localparam logic [11:0] ADDR_PWR_CTRL  = 12'h004;
  localparam logic [11:0] ADDR_STATUS    = 12'h008;

  localparam int          PC_SM2         = 7;
  localparam int          PC_SE          = 6;
  localparam int          PC_SM1         = 5;
  localparam int          PC_SM0         = 4;
  localparam logic [7:0]  PWR_CTRL_RST   = 8'h00;
  localparam logic [7:0]  RC_TRIM_RST    = 8'h00;

  localparam logic [3:0]  CLOCK_SOURCE_SELECT_FUSES_EXT      = 4'h0;
  localparam logic [3:0]  CLOCK_SOURCE_SELECT_FUSES_RC_1M    = 4'h1;
  localparam logic [3:0]  CLOCK_SOURCE_SELECT_FUSES_RC_8M    = 4'h4;
  localparam logic [3:0]  CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN = 4'h9;

  localparam logic [1:0]  SUT_NO_DLY     = 2'h0;
  localparam logic [1:0]  SUT_SHORT      = 2'h1;
  localparam logic [1:0]  SUT_RST        = 2'h2;

  // Start-up and wake hold in core clock cycles
  localparam int          STARTUP_CK     = 6;
  localparam int          WAKE_HOLD_CK   = 4;

  // Reset delays, counted on watchdog oscillator ticks
  localparam int          DLY_SHORT_US   = 4100;
  localparam int          DLY_LONG_US    = 65000;
  localparam int          WDT_PERIOD_NS  = 1000;
  localparam int          DLY_SHORT_TICKS =
    (DLY_SHORT_US * 1000 + WDT_PERIOD_NS - 1) / WDT_PERIOD_NS;
  localparam int          DLY_LONG_TICKS  =
    (DLY_LONG_US * 1000 + WDT_PERIOD_NS - 1) / WDT_PERIOD_NS;
  localparam int          CNT_W          = 17;

  typedef enum logic [2:0] {
    SM_IDLE     = 3'b000,
    SM_ADC_NR   = 3'b001,
    SM_PWR_DOWN = 3'b010,
    SM_PWR_SAVE = 3'b011,
    SM_RSVD_4   = 3'b100,
    SM_RSVD_5   = 3'b101,
    SM_STANDBY  = 3'b110,
    SM_EXT_STBY = 3'b111
  } csc_sleep_mode_t;

  typedef enum logic [2:0] {
    ST_RESET_DLY = 3'b000,
    ST_RUN       = 3'b001,
    ST_SLEEP     = 3'b010,
    ST_STARTUP   = 3'b011,
    ST_WAKE_HOLD = 3'b100
  } csc_state_t;

  typedef enum logic [1:0] {
    SRC_EXT   = 2'b00,
    SRC_RC    = 2'b01,
    SRC_XTAL  = 2'b10,
    SRC_OTHER = 2'b11
  } csc_src_t;

  typedef struct packed {
    logic core;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
  } csc_clk_en_t;

  typedef struct packed {
    logic ext_pin;
    logic twi_match;
    logic timer2;
    logic spm_ready;
    logic adc_done;
    logic other_io;
  } csc_wake_t;

  localparam csc_clk_en_t CLK_ALL_ON = 6'h3f;

endpackage

// >>> rtl/csc_top.sv
// Clock source selection, reset time-out and sleep control
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
module csc_top #(
  parameter int DLY_SHORT = csc_pkg::DLY_SHORT_TICKS,
  parameter int DLY_LONG  = csc_pkg::DLY_LONG_TICKS
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [3:0]           clock_source_select_fuses,
  input  wire logic [1:0]           startup_time_fuses,
  input  wire logic [7:0]           calibration_byte,
  input  wire logic                 wdt_tick,
  input  wire logic                 halt_req,
  input  wire logic                 adc_enabled,
  input  wire csc_pkg::csc_wake_t   wake_irq,
  output logic                      core_hold,
  output logic                      resume_irq,
  output logic                      adc_start,
  output csc_pkg::csc_clk_en_t      clk_en,
  output csc_pkg::csc_src_t         clk_source,
  output logic [1:0]                rc_range,
  output logic [7:0]                rc_trim,
  output logic [3:0]                ext_irq_sense
);

  csc_pkg::csc_state_t      state_ff;
  csc_pkg::csc_state_t      nxt_state;
  logic [csc_pkg::CNT_W-1:0] cnt_ff;
  logic [csc_pkg::CNT_W-1:0] nxt_cnt;
  logic [csc_pkg::CNT_W-1:0] dly_target;
  logic                     fuse_load_ff;
  logic [3:0]               clock_source_select_fuses_ff;
  logic [1:0]               sut_ff;
  logic [1:0]               rc_range_ff;
  logic [7:0]               rc_trim_ff;
  logic [7:0]               pwr_ctrl_ff;
  csc_pkg::csc_sleep_mode_t mode_ff;
  logic                     from_reset_ff;
  logic                     pready_ff;
  logic                     pslverr_ff;
  logic [31:0]              prdata_ff;
  logic                     core_hold_ff;
  logic                     resume_irq_ff;
  logic                     adc_start_ff;
  csc_pkg::csc_clk_en_t     clk_en_ff;
  csc_pkg::csc_src_t        clk_source_ff;
  csc_pkg::csc_sleep_mode_t req_mode;
  logic                     sleep_go;
  logic                     wr_en;
  logic                     mapped;

  // Clock domains left running in each sleep mode
  function automatic csc_pkg::csc_clk_en_t sleep_clocks(
    input csc_pkg::csc_sleep_mode_t m
  );
    csc_pkg::csc_clk_en_t c;
    c = '0;
    case (m)
      csc_pkg::SM_IDLE:
      begin
        c          = csc_pkg::CLK_ALL_ON;
        c.core     = 1'b0;
        c.flash    = 1'b0;
      end
      csc_pkg::SM_ADC_NR:
      begin
        c.adc      = 1'b1;
        c.asy      = 1'b1;
        c.main_osc = 1'b1;
      end
      csc_pkg::SM_PWR_SAVE:
        c.asy      = 1'b1;
      csc_pkg::SM_STANDBY:
        c.main_osc = 1'b1;
      csc_pkg::SM_EXT_STBY:
      begin
        c.asy      = 1'b1;
        c.main_osc = 1'b1;
      end
      default:
        c          = '0;
    endcase
    return c;
  endfunction

  // Which interrupt sources may end each sleep mode
  function automatic logic wake_ok(
    input csc_pkg::csc_sleep_mode_t m,
    input csc_pkg::csc_wake_t       w
  );
    logic base;
    base = w.ext_pin | w.twi_match;
    case (m)
      csc_pkg::SM_IDLE:
        wake_ok = |w;
      csc_pkg::SM_ADC_NR:
        wake_ok = base | w.timer2 | w.spm_ready | w.adc_done;
      csc_pkg::SM_PWR_SAVE,
      csc_pkg::SM_EXT_STBY:
        wake_ok = base | w.timer2;
      default:
        wake_ok = base;
    endcase
  endfunction

  // Modes that stop the oscillator or gate it need the start-up count
  function automatic logic needs_startup(
    input csc_pkg::csc_sleep_mode_t m
  );
    needs_startup = (m != csc_pkg::SM_IDLE) && (m != csc_pkg::SM_ADC_NR);
  endfunction

  assign req_mode = csc_pkg::csc_sleep_mode_t'({pwr_ctrl_ff[csc_pkg::PC_SM2],
                                               pwr_ctrl_ff[csc_pkg::PC_SM1],
                                               pwr_ctrl_ff[csc_pkg::PC_SM0]});

  // Reserved modes and standby without a crystal leave halt without effect
  always_comb
  begin
    sleep_go = halt_req && pwr_ctrl_ff[csc_pkg::PC_SE];
    if (req_mode == csc_pkg::SM_RSVD_4 || req_mode == csc_pkg::SM_RSVD_5)
    begin
      sleep_go = 1'b0;
    end
    else if ((req_mode == csc_pkg::SM_STANDBY ||
              req_mode == csc_pkg::SM_EXT_STBY) &&
             (clock_source_select_fuses_ff < csc_pkg::CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN))
    begin
      sleep_go = 1'b0;
    end
  end

  // Extra reset delay chosen by the start-up fuses
  always_comb
  begin
    if (sut_ff == csc_pkg::SUT_NO_DLY)
    begin
      dly_target = '0;
    end
    else if (sut_ff == csc_pkg::SUT_SHORT)
    begin
      dly_target = csc_pkg::CNT_W'(DLY_SHORT);
    end
    else
    begin
      // Reserved code treated as the longest delay
      dly_target = csc_pkg::CNT_W'(DLY_LONG);
    end
  end

  // Fuses and factory trim are captured on the first edge after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fuse_load_ff <= 1'b1;
      clock_source_select_fuses_ff     <= csc_pkg::CLOCK_SOURCE_SELECT_FUSES_RC_1M;
      sut_ff       <= csc_pkg::SUT_RST;
      rc_range_ff  <= csc_pkg::CLOCK_SOURCE_SELECT_FUSES_RC_1M[1:0] - 2'h1;
    end
    else if (fuse_load_ff)
    begin
      fuse_load_ff <= 1'b0;
      clock_source_select_fuses_ff     <= clock_source_select_fuses;
      sut_ff       <= startup_time_fuses;
      rc_range_ff  <= clock_source_select_fuses[1:0] - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_source_ff <= csc_pkg::SRC_RC;
    else if (clock_source_select_fuses_ff == csc_pkg::CLOCK_SOURCE_SELECT_FUSES_EXT)
      clk_source_ff <= csc_pkg::SRC_EXT;
    else if (clock_source_select_fuses_ff <= csc_pkg::CLOCK_SOURCE_SELECT_FUSES_RC_8M)
      clk_source_ff <= csc_pkg::SRC_RC;
    else if (clock_source_select_fuses_ff >= csc_pkg::CLOCK_SOURCE_SELECT_FUSES_XTAL_MIN)
      clk_source_ff <= csc_pkg::SRC_XTAL;
    else
      clk_source_ff <= csc_pkg::SRC_OTHER;
  end

  // APB: zero wait states, answer in the access cycle
  assign mapped = (paddr == csc_pkg::ADDR_RC_TRIM) ||
                  (paddr == csc_pkg::ADDR_PWR_CTRL) ||
                  (paddr == csc_pkg::ADDR_STATUS);
  assign wr_en  = psel && penable && pready_ff && pwrite && mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end
    else
    begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == csc_pkg::ADDR_RC_TRIM)
        begin
          prdata_ff <= {24'h000000, rc_trim_ff};
        end
        else if (paddr == csc_pkg::ADDR_PWR_CTRL)
        begin
          prdata_ff <= {24'h000000, pwr_ctrl_ff};
        end
        else if (paddr == csc_pkg::ADDR_STATUS)
        begin
          prdata_ff <= {16'h0000, 1'b0, state_ff, clk_source_ff,
                        sut_ff, clock_source_select_fuses_ff, 4'h0};
        end
        else
        begin
          prdata_ff <= '0;
        end
      end
    end
  end

  // Factory value loaded before the core runs; software may retune later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rc_trim_ff <= csc_pkg::RC_TRIM_RST;
    else if (fuse_load_ff)
      rc_trim_ff <= calibration_byte;
    else if (wr_en && paddr == csc_pkg::ADDR_RC_TRIM)
      rc_trim_ff <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_ctrl_ff <= csc_pkg::PWR_CTRL_RST;
    else if (wr_en && paddr == csc_pkg::ADDR_PWR_CTRL)
      pwr_ctrl_ff <= pwdata[7:0];
  end

  // Sequencer: reset time-out, run, sleep, start-up and wake hold
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      csc_pkg::ST_RESET_DLY:
      begin
        if (!fuse_load_ff && cnt_ff >= dly_target)
        begin
          nxt_state = csc_pkg::ST_STARTUP;
          nxt_cnt   = '0;
        end
        else if (!fuse_load_ff && wdt_tick)
        begin
          nxt_cnt   = cnt_ff + 1'b1;
        end
      end
      csc_pkg::ST_RUN:
      begin
        if (sleep_go)
        begin
          nxt_state = csc_pkg::ST_SLEEP;
        end
      end
      csc_pkg::ST_SLEEP:
      begin
        nxt_cnt = '0;
        if (wake_ok(mode_ff, wake_irq))
        begin
          nxt_state = needs_startup(mode_ff) ? csc_pkg::ST_STARTUP
                                             : csc_pkg::ST_WAKE_HOLD;
        end
      end
      csc_pkg::ST_STARTUP:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == csc_pkg::CNT_W'(csc_pkg::STARTUP_CK - 1))
        begin
          nxt_state = from_reset_ff ? csc_pkg::ST_RUN
                                    : csc_pkg::ST_WAKE_HOLD;
          nxt_cnt   = '0;
        end
      end
      csc_pkg::ST_WAKE_HOLD:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == csc_pkg::CNT_W'(csc_pkg::WAKE_HOLD_CK - 1))
        begin
          nxt_state = csc_pkg::ST_RUN;
          nxt_cnt   = '0;
        end
      end
      default:
      begin
        nxt_state = csc_pkg::ST_RESET_DLY;
        nxt_cnt   = '0;
      end
    endcase
  end

  // Reset aborts any sleep; the core restarts from its reset vector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff      <= csc_pkg::ST_RESET_DLY;
      cnt_ff        <= '0;
      from_reset_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (state_ff == csc_pkg::ST_RUN)
      begin
        from_reset_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff <= csc_pkg::SM_IDLE;
    end
    else if (state_ff == csc_pkg::ST_RUN && sleep_go)
    begin
      mode_ff <= req_mode;
    end
  end

  // Clock gating only; no storage is cleared, so contents survive sleep
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_en_ff <= csc_pkg::CLK_ALL_ON;
    end
    else if (nxt_state == csc_pkg::ST_SLEEP &&
             state_ff == csc_pkg::ST_RUN)
    begin
      clk_en_ff <= sleep_clocks(req_mode);
    end
    else if (nxt_state != csc_pkg::ST_SLEEP)
    begin
      clk_en_ff <= csc_pkg::CLK_ALL_ON;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_hold_ff  <= 1'b1;
      resume_irq_ff <= 1'b0;
      adc_start_ff  <= 1'b0;
    end
    else
    begin
      core_hold_ff  <= (nxt_state != csc_pkg::ST_RUN);
      resume_irq_ff <= (state_ff == csc_pkg::ST_WAKE_HOLD) &&
                       (nxt_state == csc_pkg::ST_RUN);
      adc_start_ff  <= (state_ff == csc_pkg::ST_RUN) && sleep_go &&
                       adc_enabled &&
                       (req_mode == csc_pkg::SM_IDLE ||
                        req_mode == csc_pkg::SM_ADC_NR);
    end
  end

  // Trim drives the oscillator directly; a larger code means faster
  assign rc_trim       = rc_trim_ff;
  assign rc_range      = rc_range_ff;
  assign ext_irq_sense = pwr_ctrl_ff[3:0];
  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign core_hold     = core_hold_ff;
  assign resume_irq    = resume_irq_ff;
  assign adc_start     = adc_start_ff;
  assign clk_en        = clk_en_ff;
  assign clk_source    = clk_source_ff;

endmodule

// >>> tb/csc_core_model.sv
// Core model: issues halt pulses and counts interrupt handler runs
`timescale 1ns/100ps
module csc_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       issue,
  input  wire logic [3:0] lag,
  input  wire logic       core_hold,
  input  wire logic       resume_irq,
  output logic            halt_req,
  output logic [7:0]      handler_cnt
);
  logic       pend_ff;
  logic [3:0] wait_ff;

  // A held core executes nothing, so no halt then
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pend_ff  <= 1'b0;
      wait_ff  <= 4'h0;
      halt_req <= 1'b0;
    end
    else
    begin
      halt_req <= 1'b0;
      if (issue)
      begin
        pend_ff <= 1'b1;
        wait_ff <= lag;
      end
      else if (pend_ff && wait_ff != 4'h0)
        wait_ff <= wait_ff - 4'h1;
      else if (pend_ff && !core_hold)
      begin
        halt_req <= 1'b1;
        pend_ff  <= 1'b0;
      end
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      handler_cnt <= 8'h00;
    else if (resume_irq)
      handler_cnt <= handler_cnt + 8'h01;
endmodule

// >>> tb/csc_props.sv
// Port assertions for the clock source and sleep control block
`timescale 1ns/100ps
module csc_props #(
  parameter int DLY_SHORT = 3,
  parameter int DLY_LONG  = 5
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [7:0]           calibration_byte,
  input wire logic                 halt_req,
  input wire logic                 adc_enabled,
  input wire logic                 core_hold,
  input wire logic                 resume_irq,
  input wire logic                 adc_start,
  input wire csc_pkg::csc_clk_en_t clk_en,
  input wire logic [7:0]           rc_trim
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_released;
    $past(presetn) && !$past(presetn, 2);
  endsequence
  sequence s_held4;
    core_hold [*4];
  endsequence

  apb_ready_a: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error outside access");
  trim_load_a: assert property (
    s_released |-> rc_trim == $past(calibration_byte))
    else $error("trim not loaded in reset");
  gated_held_a: assert property (!clk_en.core |-> core_hold)
    else $error("core clock off while running");
  sleep_entry_a: assert property (
    $fell(clk_en.core) |-> $past(halt_req) && core_hold)
    else $error("clock gated without halt");
  resume_pulse_a: assert property (
    resume_irq |-> !core_hold ##1 !resume_irq)
    else $error("bad resume pulse");
  wake_hold_a: assert property (
    $rose(clk_en.core) |-> s_held4 ##[1:7] (resume_irq && !core_hold))
    else $error("wake hold wrong");
  adc_cause_a: assert property (
    adc_start |-> $past(halt_req) && $past(adc_enabled) ##1 !adc_start)
    else $error("conversion start without idle entry");
endmodule

bind csc_top csc_props #(.DLY_SHORT(DLY_SHORT), .DLY_LONG(DLY_LONG)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .calibration_byte(calibration_byte),
  .halt_req(halt_req), .adc_enabled(adc_enabled), .core_hold(core_hold),
  .resume_irq(resume_irq), .adc_start(adc_start), .clk_en(clk_en),
  .rc_trim(rc_trim));

// >>> tb/test_clock_source_and_sleep_control.sv
// Bench: fuse decode, registers, sleep entry, wake, reset in sleep
`timescale 1ns/100ps
module test_clock_source_and_sleep_control;
  logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic                 penable = 1'b0, pwrite = 1'b0, wdt_tick = 1'b0;
  logic                 adc_en = 1'b0, issue = 1'b0, tick_on = 1'b1;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0, prdata;
  logic                 pready, pslverr, halt_req;
  logic                 core_hold, resume_irq, adc_start;
  logic [3:0]           fuse_src = 4'h1, lag = 4'h0, ext_irq_sense;
  logic [1:0]           fuse_su = 2'h0, rc_range;
  logic [7:0]           cal = 8'h00, rc_trim, handler_cnt;
  logic [2:0]           tdiv = 3'h0;
  logic [32:0]          exp_q[$], ex;
  csc_pkg::csc_wake_t   wake = 6'h00;
  csc_pkg::csc_clk_en_t clk_en;
  csc_pkg::csc_src_t    clk_source;
  int                   err_count = 0, n_checks = 0, cyc = 0, adc_cnt = 0;
  int                   i;
  int                   hk = csc_pkg::WAKE_HOLD_CK + 2;
  int                   sk = csc_pkg::WAKE_HOLD_CK + 2 + csc_pkg::STARTUP_CK;

  always #2.5 pclk = ~pclk;

  // Short reset delays keep the run brief
  csc_top #(.DLY_SHORT(3), .DLY_LONG(5)) u_dut (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clock_source_select_fuses(fuse_src),
    .startup_time_fuses(fuse_su), .calibration_byte(cal),
    .wdt_tick(wdt_tick), .halt_req(halt_req), .adc_enabled(adc_en),
    .wake_irq(wake), .core_hold(core_hold), .resume_irq(resume_irq),
    .adc_start(adc_start), .clk_en(clk_en), .clk_source(clk_source),
    .rc_range(rc_range), .rc_trim(rc_trim), .ext_irq_sense(ext_irq_sense));

  csc_core_model u_core (.pclk(pclk), .presetn(presetn), .issue(issue),
    .lag(lag), .core_hold(core_hold), .resume_irq(resume_irq),
    .halt_req(halt_req), .handler_cnt(handler_cnt));

  task automatic check(string nm, logic [31:0] s, logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [32:0] x);
    int n;
    n = 0;
    exp_q.push_back(x);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 9);
    if (n == 9)
      err_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic do_reset(logic [3:0] f, logic [1:0] s);
    presetn <= 1'b0;
    fuse_src <= f;
    fuse_su <= s;
    cal <= 8'($urandom);
    repeat (4) @(posedge pclk);
    check("held", 32'(core_hold), 32'h1);
    check("clocks on", 32'(clk_en), 32'h3f);
    presetn <= 1'b1;
  endtask

  task automatic wait_run;
    int n;
    int lo;
    n = 0;
    // Tick every 8 cycles at an unknown phase: up to 7 cycles late
    lo = fuse_su == 2'h0 ? 9 : fuse_su == 2'h1 ? 26 : 42;
    while (core_hold !== 1'b0 && n < 80)
    begin
      @(posedge pclk);
      n++;
    end
    check("released", 32'(core_hold), 32'h0);
    check("delay", 32'(n >= lo && n <= lo + 7), 32'h1);
    check("trim", 32'(rc_trim), 32'(cal));
  endtask

  // Negative n_exp: halt refused; zero: left asleep
  task automatic nap(logic [2:0] m, logic en, csc_pkg::csc_wake_t wn, w,
                     int n_exp, logic [5:0] ce, mk);
    logic [7:0] pc;
    int         n;
    pc = {m[2], en, m[1:0], 4'($urandom)};
    n = 0;
    apb(1'b1, csc_pkg::ADDR_PWR_CTRL, {24'h0, pc}, 33'h0);
    check("sense", 32'(ext_irq_sense), 32'(pc[3:0]));
    apb(1'b0, csc_pkg::ADDR_PWR_CTRL, 32'h0, {25'h0, pc});
    lag <= 4'($urandom_range(3));
    issue <= 1'b1;
    @(posedge pclk);
    issue <= 1'b0;
    while (halt_req !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    check("halt issued", 32'(halt_req), 32'h1);
    @(posedge pclk);
    check("hold", 32'(core_hold), 32'(n_exp >= 0));
    check("gating", 32'(clk_en & mk),
          32'((n_exp < 0 ? 6'h3f : ce) & mk));
    if (n_exp <= 0)
      return;
    wake <= wn;
    repeat (8) @(posedge pclk);
    check("no wake", 32'(core_hold), 32'h1);
    wake <= w;
    n = 0;
    do
      @(posedge pclk);
    while (resume_irq !== 1'b1 && ++n < 40);
    wake <= 6'h00;
    check("wake cycles", 32'(n + 1), 32'(n_exp));
    apb(1'b1, csc_pkg::ADDR_PWR_CTRL, {24'h0, pc & 8'hbf}, 33'h0);
  endtask

  always @(posedge pclk)
  begin
    tdiv <= tdiv + 3'h1;
    wdt_tick <= tick_on && tdiv == 3'h7;
    if (adc_start === 1'b1)
      adc_cnt++;
    if (++cyc == 10000)
    begin
      err_count++;
      finish_test();
    end
  end

  always @(posedge pclk)
    if (psel && penable && pready)
    begin
      ex = exp_q.pop_front();
      check("slverr", 32'(pslverr), 32'(ex[32]));
      if (!pwrite)
        check("prdata", prdata, ex[31:0]);
    end

  initial
  begin
    logic [7:0] t;
    void'($urandom(38171));
    for (i = 0; i < 6; i++)
    begin
      do_reset(4'(i), 2'(i % 3));
      wait_run();
      check("source", 32'(clk_source), 32'(i == 0 ? csc_pkg::SRC_EXT
            : i == 5 ? csc_pkg::SRC_OTHER : csc_pkg::SRC_RC));
      if (i > 0 && i < 5)
        check("range", 32'(rc_range), 32'(i - 1));
    end
    apb(1'b0, csc_pkg::ADDR_RC_TRIM, 32'h0, {25'h0, cal});
    apb(1'b0, csc_pkg::ADDR_PWR_CTRL, 32'h0, 33'h0);
    t = 8'($urandom);
    apb(1'b1, csc_pkg::ADDR_RC_TRIM, {24'h0, t}, 33'h0);
    apb(1'b0, csc_pkg::ADDR_RC_TRIM, 32'h0, {25'h0, t});
    check("trim port", 32'(rc_trim), 32'(t));
    apb(1'b1, csc_pkg::ADDR_RC_TRIM, {24'h0, cal}, 33'h0);
    apb(1'b0, csc_pkg::ADDR_STATUS, 32'h0, {18'h0, csc_pkg::ST_RUN,
        csc_pkg::SRC_OTHER, fuse_su, fuse_src, 4'h0});
    apb(1'b0, 12'h00c, 32'h0, 33'h100000000);
    apb(1'b1, 12'hffc, 32'hffffffff, 33'h100000000);
    adc_en <= 1'b1;
    nap(3'h0, 1'b1, 6'h00, 6'h01, hk, 6'h0f, 6'h3f);
    nap(3'h1, 1'b1, 6'h01, 6'h02, hk, 6'h07, 6'h3f);
    nap(3'h2, 1'b1, 6'h0f, 6'h20, sk, 6'h00, 6'h3f);
    nap(3'h3, 1'b1, 6'h07, 6'h08, sk, 6'h00, 6'h3d);
    nap(3'h0, 1'b0, 6'h00, 6'h00, -1, 6'h00, 6'h3f);
    for (i = 4; i < 8; i++)
      nap(3'(i), 1'b1, 6'h00, 6'h00, -1, 6'h00, 6'h3f);
    check("handler runs", 32'(handler_cnt), 32'h4);
    check("conversions", 32'(adc_cnt), 32'h2);
    do_reset(4'h9, 2'h3);
    wait_run();
    check("crystal", 32'(clk_source), 32'(csc_pkg::SRC_XTAL));
    nap(3'h6, 1'b1, 6'h0f, 6'h10, sk, 6'h01, 6'h3f);
    nap(3'h7, 1'b1, 6'h07, 6'h08, sk, 6'h01, 6'h3d);
    tick_on <= 1'b0;
    nap(3'h2, 1'b1, 6'h00, 6'h00, 0, 6'h00, 6'h3f);
    do_reset(4'h1, 2'h1);
    repeat (30) @(posedge pclk);
    check("no tick", 32'(core_hold), 32'h1);
    tick_on <= 1'b1;
    wait_run();
    finish_test();
  end
endmodule
